/* File: hw/csr_pkg.sv */
// Constants for the chip-select, refresh and bus-control output block
package csr_pkg;
	// Register port widths
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// Register offsets
	localparam logic [3:0] OFS_MID_BASE   = 4'h0;
	localparam logic [3:0] OFS_PERIPH_BASE = 4'h1;
	localparam logic [3:0] OFS_MID_PERIPH  = 4'h2;
	localparam logic [3:0] OFS_BUS_WIDTH   = 4'h3;
	localparam logic [3:0] OFS_REFRESH     = 4'h4;
	localparam logic [3:0] OFS_LOWER_CTRL  = 4'h5;
	localparam logic [3:0] OFS_UPPER_CTRL  = 4'h6;
	localparam logic [3:0] OFS_STATUS      = 4'h7;

	// Field positions
	localparam int MID_BASE_LSB    = 9;
	localparam int MID_SIZE_LSB    = 0;
	localparam int AUX_PERIPH_MEM  = 0;
	localparam int AUX_WHOLE_MID   = 6;
	localparam int AUX_EXT_BIT     = 7;
	localparam int WIDTH_MID_BIT   = 1;
	localparam int REFRESH_EN_BIT  = 15;
	localparam int REFRESH_PS_BIT  = 14;
	localparam int SPLIT_ADDR_BIT  = 7;

	// Reset values
	localparam logic [15:0] MID_BASE_RST    = 16'h0000;
	localparam logic [15:0] PERIPH_BASE_RST = 16'h0000;
	localparam logic [15:0] MID_PERIPH_RST  = 16'h0080;
	localparam logic [15:0] BUS_WIDTH_RST   = 16'h0000;
	localparam logic [15:0] REFRESH_RST     = 16'h0000;
	localparam logic [15:0] REGION_CTRL_RST = 16'h0000;

	// Address decode constants
	localparam int          MID_BLOCK_SHIFT = 13;
	localparam int          PERIPH_REGIONS  = 7;
	localparam logic [2:0]  PERIPH_HOLE     = 3'h4;
	localparam logic [19:0] RESET_FETCH_ADDR = 20'hFFFF0;

	// Timing: internal clock runs at twice the bus output clock
	localparam int CLK_PERIOD_NS     = 10;
	localparam int CLKOUT_DIV        = 2;
	localparam int REFRESH_LOW_HALF  = 3;
	localparam int REFRESH_LOW_CYC   = REFRESH_LOW_HALF * CLKOUT_DIV / 2;
	localparam int REFRESH_TOTAL_CYC = 8 * CLKOUT_DIV;
	localparam int FETCH_DELAY_HALF  = 13;
	localparam int FETCH_DELAY_CYC   = FETCH_DELAY_HALF * CLKOUT_DIV / 2;
	localparam int RESET_HOLD_NS     = 1000000;
	localparam int RESET_HOLD_CYC    = RESET_HOLD_NS / CLK_PERIOD_NS;

	// Bus cycle sequencer states
	typedef enum logic [2:0] {
		CSR_IDLE,
		CSR_ADDR,
		CSR_TURN,
		CSR_DATA,
		CSR_HOLD
	} csr_state_t;
endpackage

/* File: hw/csr_bus_outputs.sv */
// Chip-select decode, refresh strobe, latched address and read strobe logic
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ns
// Function
// R1: Second and third midrange selects go low for accesses in their programmable region.
// R2: Midrange selects report 8- or 16-bit width from bus width register bit 1.
// R3: All midrange selects stay high while an external master owns the bus; fourth pin still pulses refresh if refresh bit 15 set.
// R4: Whole-range first midrange select releases second to fourth pins as I/O.
// R5: Fourth midrange select goes low for accesses in the fourth midrange region.
// R6: Refresh pulse appears on fourth midrange pin only when refresh bit 15 set.
// R7: Refresh strobe low 1.5 output clocks, then high for rest of cycle.
// R8: Refresh output keeps driving, never floated, during external bus hold.
// R9: Each peripheral select covers its 256-byte region, memory or I/O space.
// R10: Peripheral selects stay high during reset and during bus hold.
// R11: With extension bit 7 clear, sixth and seventh pins show latched A1, A2.
// R12: Latched address bits keep their last values during bus hold.
// R13: Read strobe asserts in read cycles only after the address bus floats.
// R14: Read strobe floats while an external master owns the bus.
// R15: Narrow variant drives secondary refresh low during each dynamic refresh cycle.
// R16: Strap high: lower/upper cycles with split flag keep address off shared bus.
// R17: Strap low: shared bus always multiplexes address and data.
// R18: Strap sampled one cycle after reset release; pin floats in hold and float mode.
// R19: Reset held at least 1 ms, may be asynchronous to the output clock.
// R20: First fetch starts 6.5 output clocks after reset release, at FFFF0h.
// R21: Hold request finishes current cycle, acknowledges, floats, then selects high.
// R22: At most one chip select per bus cycle, released when the cycle ends.
module csr_bus_outputs #(
	parameter logic NARROW_VARIANT = 1'b1
) (
	// Clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     rst_in,
	// Register port
	input  wire logic [csr_pkg::ADDR_W-1:0] reg_addr_in,
	input  wire logic [csr_pkg::DATA_W-1:0] reg_wdata_in,
	input  wire logic                     reg_wr_in,
	input  wire logic                     reg_rd_in,
	output logic      [csr_pkg::DATA_W-1:0] reg_rdata_out,
	// Bus cycle requests from the core
	input  wire logic                     cyc_start_in,
	input  wire logic [19:0]              cyc_addr_in,
	input  wire logic                     cyc_mem_in,
	input  wire logic                     cyc_read_in,
	input  wire logic                     cyc_lower_in,
	input  wire logic                     cyc_upper_in,
	input  wire logic                     cyc_end_in,
	output logic                          cyc_busy_out,
	// Pins from outside
	input  wire logic                     hold_req_in,
	input  wire logic                     strap_addr_en_in,
	input  wire logic                     float_mode_in,
	// Bus hold and address phase
	output logic                          hold_ack_out,
	output logic                          ad_addr_drive_out,
	output logic                          addr_split_out,
	output logic                          mid_bus_16bit_out,
	output logic                          bus_clk_out,
	// Reset fetch
	output logic                          first_fetch_out,
	output logic      [19:0]              fetch_addr_out,
	// Midrange selects, active low, with drive enables
	output logic                          midrange_select_first_n_out,
	output logic                          midrange_select_second_n_out,
	output logic                          midrange_select_third_n_out,
	output logic                          midrange_select_fourth_n_out,
	output logic      [3:0]               midrange_select_oe_out,
	// Peripheral selects, active low; bit 4 has no pin
	output logic      [6:0]               periph_select_n_out,
	// Read strobe, active low, with drive enable
	output logic                          read_strobe_n_out,
	output logic                          read_strobe_oe_out,
	// Secondary refresh, active low, with drive enable
	output logic                          dram_refresh_flag_low_n_out,
	output logic                          dram_refresh_flag_low_oe_out
);
	import csr_pkg::*;

	// Software registers
	logic [15:0] mid_base_reg;
	logic [15:0] periph_base_reg;
	logic [15:0] mid_periph_aux_reg;
	logic [15:0] bus_width_config_reg;
	logic [15:0] refresh_mode_reg;
	logic [15:0] lower_region_ctrl_reg;
	logic [15:0] upper_region_ctrl_reg;

	// Internal state
	csr_state_t  state_reg;
	logic        hold_meta_reg;
	logic        hold_sync_reg;
	logic        strap_meta_reg;
	logic        strap_sync_reg;
	logic        strap_pending_reg;
	logic        strap_high_reg;
	logic        read_cyc_reg;
	logic [3:0]  mid_hit_reg;
	logic [6:0]  periph_hit_reg;
	logic        latched_addr_bit_one_reg;
	logic        latched_addr_bit_two_reg;
	logic [15:0] refresh_cnt_reg;
	logic [4:0]  refresh_phase_reg;
	logic        refresh_active_reg;
	logic        refresh_strobe_reg;
	logic [4:0]  fetch_cnt_reg;
	logic        fetch_armed_reg;
	logic        clk_div_reg;

	// Midrange decode of one address
	function automatic logic [3:0] mid_decode(input logic [19:0] addr,
	                                          input logic [15:0] base_r,
	                                          input logic        whole);
		logic [19:0] base_a;
		logic [19:0] offs;
		logic [19:0] blk;
		logic [2:0]  size;
		logic [1:0]  idx;
		size = base_r[MID_SIZE_LSB +: 3];
		base_a = {base_r[15:MID_BASE_LSB], 13'h0000};
		offs = addr - base_a;
		blk = 20'h00001 << (MID_BLOCK_SHIFT + int'(size));
		idx = 2'(offs >> (MID_BLOCK_SHIFT - 2 + int'(size)));
		mid_decode = 4'h0;
		if (addr >= base_a && offs < blk) begin
			if (whole)
				mid_decode = 4'h1;
			else
				mid_decode = 4'(4'h1 << idx);
		end
	endfunction

	// Peripheral decode of one address
	function automatic logic [6:0] periph_decode(input logic [19:0] addr,
	                                             input logic [15:0] base_r,
	                                             input logic        mem,
	                                             input logic        mem_space);
		logic [2:0] reg_idx;
		reg_idx = addr[10:8];
		periph_decode = 7'h00;
		if (addr[19:11] == base_r[8:0] && mem == mem_space &&
		    reg_idx != 3'h7 && reg_idx != PERIPH_HOLE)
			periph_decode = 7'(7'h01 << reg_idx);
	endfunction

	logic [3:0] mid_dec;
	logic [6:0] periph_dec;
	logic       whole_mid;
	logic       ext_bit;
	logic       refresh_en;

	assign whole_mid  = mid_periph_aux_reg[AUX_WHOLE_MID];
	assign ext_bit    = mid_periph_aux_reg[AUX_EXT_BIT];
	assign refresh_en = refresh_mode_reg[REFRESH_EN_BIT];
	assign mid_dec    = cyc_mem_in ? mid_decode(cyc_addr_in, mid_base_reg, whole_mid) : 4'h0;
	assign periph_dec = periph_decode(cyc_addr_in, periph_base_reg, cyc_mem_in,
	                                  mid_periph_aux_reg[AUX_PERIPH_MEM]);

	// Register writes
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mid_base_reg          <= MID_BASE_RST;
			periph_base_reg       <= PERIPH_BASE_RST;
			mid_periph_aux_reg    <= MID_PERIPH_RST;
			bus_width_config_reg  <= BUS_WIDTH_RST;
			refresh_mode_reg      <= REFRESH_RST;
			lower_region_ctrl_reg <= REGION_CTRL_RST;
			upper_region_ctrl_reg <= REGION_CTRL_RST;
		end else if (reg_wr_in) begin
			unique case (reg_addr_in)
				OFS_MID_BASE:    mid_base_reg          <= reg_wdata_in;
				OFS_PERIPH_BASE: periph_base_reg       <= reg_wdata_in;
				OFS_MID_PERIPH:  mid_periph_aux_reg    <= reg_wdata_in;
				OFS_BUS_WIDTH:   bus_width_config_reg  <= reg_wdata_in;
				OFS_REFRESH:     refresh_mode_reg      <= reg_wdata_in;
				OFS_LOWER_CTRL:  lower_region_ctrl_reg <= reg_wdata_in;
				OFS_UPPER_CTRL:  upper_region_ctrl_reg <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// Register reads, data one cycle after the strobe
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				OFS_MID_BASE:    reg_rdata_out <= mid_base_reg;
				OFS_PERIPH_BASE: reg_rdata_out <= periph_base_reg;
				OFS_MID_PERIPH:  reg_rdata_out <= mid_periph_aux_reg;
				OFS_BUS_WIDTH:   reg_rdata_out <= bus_width_config_reg;
				OFS_REFRESH:     reg_rdata_out <= refresh_mode_reg;
				OFS_LOWER_CTRL:  reg_rdata_out <= lower_region_ctrl_reg;
				OFS_UPPER_CTRL:  reg_rdata_out <= upper_region_ctrl_reg;
				OFS_STATUS:      reg_rdata_out <= {12'h000, refresh_active_reg,
				                                   state_reg == CSR_HOLD,
				                                   hold_sync_reg, strap_high_reg};
				default:         reg_rdata_out <= 16'h0000;
			endcase
		end else begin
			reg_rdata_out <= 16'h0000;
		end
	end

	// Pin synchronisers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hold_meta_reg  <= 1'b0;
			hold_sync_reg  <= 1'b0;
		end else begin
			hold_meta_reg  <= hold_req_in;
			hold_sync_reg  <= hold_meta_reg;
		end
	end

	// Strap synchroniser runs through reset so the pin is settled at release
	always_ff @(posedge clk_in) begin
		strap_meta_reg <= strap_addr_en_in;
		strap_sync_reg <= strap_meta_reg;
	end

	// Strap capture one cycle after reset release
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			strap_pending_reg <= 1'b1;
			strap_high_reg    <= 1'b0;
		end else if (strap_pending_reg) begin
			strap_pending_reg <= 1'b0; // R18
			strap_high_reg    <= strap_sync_reg; // R18
		end
	end

	// Bus cycle sequencer and hold handshake
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg         <= CSR_IDLE;
			read_cyc_reg      <= 1'b0;
			ad_addr_drive_out <= 1'b0;
			addr_split_out    <= 1'b0;
			hold_ack_out      <= 1'b0;
			cyc_busy_out      <= 1'b0;
		end else begin
			unique case (state_reg)
				CSR_IDLE: begin
					if (hold_sync_reg) begin
						state_reg    <= CSR_HOLD; // R21
						hold_ack_out <= 1'b1; // R21
						cyc_busy_out <= 1'b1;
					end else if (cyc_start_in) begin
						state_reg         <= CSR_ADDR;
						read_cyc_reg      <= cyc_read_in;
						ad_addr_drive_out <= 1'b1;
						cyc_busy_out      <= 1'b1;
						addr_split_out    <= strap_high_reg &&
							((cyc_lower_in && lower_region_ctrl_reg[SPLIT_ADDR_BIT]) ||
							 (cyc_upper_in && upper_region_ctrl_reg[SPLIT_ADDR_BIT])); // R16 R17
					end
				end
				CSR_ADDR: begin
					state_reg         <= CSR_TURN;
					ad_addr_drive_out <= 1'b0; // R13
				end
				CSR_TURN: begin
					state_reg <= CSR_DATA;
				end
				CSR_DATA: begin
					if (cyc_end_in) begin
						state_reg      <= CSR_IDLE; // R22
						read_cyc_reg   <= 1'b0;
						addr_split_out <= 1'b0;
						cyc_busy_out   <= 1'b0;
					end
				end
				CSR_HOLD: begin
					if (!hold_sync_reg) begin
						state_reg    <= CSR_IDLE;
						hold_ack_out <= 1'b0;
						cyc_busy_out <= 1'b0;
					end
				end
			endcase
		end
	end

	// Read strobe, only once the shared bus has floated
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			read_strobe_n_out  <= 1'b1;
			read_strobe_oe_out <= 1'b1;
		end else begin
			read_strobe_oe_out <= !(state_reg == CSR_HOLD || (state_reg == CSR_IDLE &&
			                        hold_sync_reg)); // R14
			if (state_reg == CSR_TURN && read_cyc_reg && !ad_addr_drive_out)
				read_strobe_n_out <= 1'b0; // R13
			else if (state_reg != CSR_DATA || cyc_end_in)
				read_strobe_n_out <= 1'b1;
		end
	end

	// Chip select hits, captured at the address phase
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mid_hit_reg       <= 4'h0;
			periph_hit_reg    <= 7'h00;
			mid_bus_16bit_out <= 1'b0;
		end else if (state_reg == CSR_IDLE && cyc_start_in && !hold_sync_reg) begin
			mid_hit_reg       <= mid_dec; // R1 R5
			periph_hit_reg    <= (mid_dec != 4'h0) ? 7'h00 : periph_dec; // R9 R22
			mid_bus_16bit_out <= (mid_dec != 4'h0) &&
			                     bus_width_config_reg[WIDTH_MID_BIT]; // R2
		end else if (state_reg == CSR_DATA && cyc_end_in) begin
			mid_hit_reg       <= 4'h0; // R22
			periph_hit_reg    <= 7'h00; // R22
			mid_bus_16bit_out <= 1'b0;
		end
	end

	// Latched low address bits, frozen outside the address phase
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			latched_addr_bit_one_reg <= 1'b0;
			latched_addr_bit_two_reg <= 1'b0;
		end else if (state_reg == CSR_IDLE && cyc_start_in && !hold_sync_reg) begin
			latched_addr_bit_one_reg <= cyc_addr_in[1]; // R12
			latched_addr_bit_two_reg <= cyc_addr_in[2]; // R12
		end
	end

	// Midrange select pins
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			midrange_select_first_n_out  <= 1'b1;
			midrange_select_second_n_out <= 1'b1;
			midrange_select_third_n_out  <= 1'b1;
			midrange_select_fourth_n_out <= 1'b1;
			midrange_select_oe_out       <= 4'hF;
		end else begin
			midrange_select_oe_out <= whole_mid ? 4'h1 : 4'hF; // R4
			if (state_reg == CSR_HOLD) begin
				midrange_select_first_n_out  <= 1'b1; // R3
				midrange_select_second_n_out <= 1'b1; // R3
				midrange_select_third_n_out  <= 1'b1; // R3
			end else begin
				midrange_select_first_n_out  <= !mid_hit_reg[0];
				midrange_select_second_n_out <= !mid_hit_reg[1]; // R1
				midrange_select_third_n_out  <= !mid_hit_reg[2]; // R1
			end
			if (refresh_en) begin
				midrange_select_oe_out[3]    <= 1'b1; // R8
				midrange_select_fourth_n_out <= !refresh_strobe_reg; // R6
			end else if (state_reg == CSR_HOLD) begin
				midrange_select_fourth_n_out <= 1'b1; // R3
			end else begin
				midrange_select_fourth_n_out <= !mid_hit_reg[3]; // R5
			end
		end
	end

	// Peripheral select pins, sixth and seventh shared with latched bits
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			periph_select_n_out <= 7'h7F; // R10
		end else begin
			for (int i = 0; i < PERIPH_REGIONS; i++) begin
				if (i >= 5 && !ext_bit)
					periph_select_n_out[i] <= (i == 5) ? latched_addr_bit_one_reg :
					                                     latched_addr_bit_two_reg; // R11
				else if (state_reg == CSR_HOLD || i == int'(PERIPH_HOLE))
					periph_select_n_out[i] <= 1'b1; // R10
				else
					periph_select_n_out[i] <= !periph_hit_reg[i]; // R9
			end
		end
	end

	// Refresh timer and strobe
	always_ff @(posedge clk_in) begin
		if (rst_in || !refresh_en) begin
			refresh_cnt_reg    <= 16'h0000;
			refresh_phase_reg  <= 5'h00;
			refresh_active_reg <= 1'b0;
			refresh_strobe_reg <= 1'b0;
		end else if (refresh_active_reg) begin
			refresh_strobe_reg <= refresh_phase_reg < 5'(REFRESH_LOW_CYC - 1); // R7
			if (refresh_phase_reg == 5'(REFRESH_TOTAL_CYC - 1)) begin
				refresh_active_reg <= 1'b0; // R7
				refresh_phase_reg  <= 5'h00;
			end else begin
				refresh_phase_reg <= refresh_phase_reg + 5'h01;
			end
		end else if (refresh_cnt_reg >= {6'h00, refresh_mode_reg[8:0], 1'b0}) begin
			refresh_cnt_reg    <= 16'h0000;
			refresh_active_reg <= 1'b1;
			refresh_strobe_reg <= 1'b1; // R6
		end else begin
			refresh_cnt_reg <= refresh_cnt_reg + 16'h0001;
		end
	end

	// Secondary refresh pin, shared with the address-enable strap
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			dram_refresh_flag_low_n_out  <= 1'b1;
			dram_refresh_flag_low_oe_out <= 1'b0;
		end else begin
			dram_refresh_flag_low_oe_out <= NARROW_VARIANT && !float_mode_in &&
			                                state_reg != CSR_HOLD; // R18
			dram_refresh_flag_low_n_out  <= !(refresh_active_reg &&
			                                  !refresh_mode_reg[REFRESH_PS_BIT]); // R15
		end
	end

	// Output clock divider and first fetch after reset
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			clk_div_reg     <= 1'b0;
			fetch_cnt_reg   <= 5'h00;
			fetch_armed_reg <= 1'b1;
			first_fetch_out <= 1'b0;
			fetch_addr_out  <= RESET_FETCH_ADDR;
		end else begin
			clk_div_reg     <= !clk_div_reg;
			first_fetch_out <= 1'b0;
			if (fetch_armed_reg) begin
				fetch_cnt_reg <= fetch_cnt_reg + 5'h01;
				if (fetch_cnt_reg == 5'(FETCH_DELAY_CYC - 1)) begin
					fetch_armed_reg <= 1'b0;
					first_fetch_out <= 1'b1; // R20
				end
			end
		end
	end

	assign bus_clk_out = clk_div_reg;

endmodule

/* File: bench/csr_bus_outputs_props.sv */
// Checker for the chip-select, refresh and bus output block
`timescale 1ns/1ns
module csr_bus_outputs_props
	import csr_pkg::*;
(
	// Clock and reset
	input wire logic        clk_in,
	input wire logic        rst_in,
	// Observed outputs
	input wire logic        cyc_busy_out,
	input wire logic        hold_ack_out,
	input wire logic        ad_addr_drive_out,
	input wire logic        first_fetch_out,
	input wire logic [19:0] fetch_addr_out,
	input wire logic        midrange_select_first_n_out,
	input wire logic        midrange_select_second_n_out,
	input wire logic        midrange_select_third_n_out,
	input wire logic        midrange_select_fourth_n_out,
	input wire logic [3:0]  midrange_select_oe_out,
	input wire logic [6:0]  periph_select_n_out,
	input wire logic        read_strobe_n_out,
	input wire logic        read_strobe_oe_out
);
	logic [7:0] sel_n;

	assign sel_n = {midrange_select_first_n_out, midrange_select_second_n_out,
		midrange_select_third_n_out, periph_select_n_out[4:0]};

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence refresh_pulse;
		(!midrange_select_fourth_n_out && midrange_select_oe_out[3]) [*3]
			##1 midrange_select_fourth_n_out;
	endsequence
	sequence fetch_wait;
		(!first_fetch_out) [*8] ##6 first_fetch_out;
	endsequence

	a_mid_hold_high: assert property (hold_ack_out && $past(hold_ack_out) |-> sel_n[7:5] == 3'h7)
		else $error("midrange select low in hold");
	a_per_hold_high: assert property (hold_ack_out && $past(hold_ack_out) |-> sel_n[4:0] == 5'h1F)
		else $error("peripheral select low in hold");
	a_per_reset_high: assert property (@(posedge clk_in) disable iff (1'b0)
		rst_in |=> periph_select_n_out == 7'h7F)
		else $error("peripheral select low in reset");
	a_rd_hold_float: assert property (hold_ack_out |-> !read_strobe_oe_out)
		else $error("read strobe driven in hold");
	a_rd_after_addr: assert property ($fell(read_strobe_n_out)
		|-> !ad_addr_drive_out && $past(ad_addr_drive_out, 2))
		else $error("read strobe before address float");
	a_refresh_width: assert property ($fell(midrange_select_fourth_n_out) && !cyc_busy_out
		|-> refresh_pulse)
		else $error("refresh strobe width wrong");
	a_refresh_hold_drive: assert property (hold_ack_out |-> midrange_select_oe_out[3])
		else $error("refresh pin floated in hold");
	a_one_select: assert property ($onehot0(~sel_n))
		else $error("several selects low");
	a_select_release: assert property ($fell(cyc_busy_out) |=> sel_n == 8'hFF)
		else $error("select held after cycle end");
	a_latch_hold: assert property (hold_ack_out && $past(hold_ack_out) && $past(hold_ack_out, 2)
		|-> $stable(periph_select_n_out[6:5]))
		else $error("latched address changed in hold");
	a_first_fetch: assert property ($fell(rst_in) |-> fetch_wait
		##1 (!first_fetch_out && fetch_addr_out == RESET_FETCH_ADDR))
		else $error("first fetch timing wrong");
endmodule

bind csr_bus_outputs csr_bus_outputs_props u_props (.*);

/* File: bench/csr_ext_bus_model.sv */
// External bus master and refresh-watching memory on the local bus
`timescale 1ns/1ns
module csr_ext_bus_model (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Bench control
	input  wire logic       hold_want_in,
	// Block pins
	input  wire logic       hold_ack_in,
	input  wire logic       refresh_n_in,
	input  wire logic       refresh_oe_in,
	output logic            hold_req_out,
	output logic [7:0]      refresh_len_out,
	output logic [7:0]      refresh_cnt_out
);
	logic [7:0] run_reg;

	// Master asks for the bus and keeps asking until told to let go
	always_ff @(posedge clk_in) begin
		hold_req_out <= !rst_in && hold_want_in;
	end

	// Memory measures each low refresh period
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			run_reg         <= 8'h00;
			refresh_len_out <= 8'h00;
			refresh_cnt_out <= 8'h00;
		end else if (refresh_oe_in && !refresh_n_in) begin
			run_reg <= run_reg + 8'h01;
		end else if (run_reg != 8'h00) begin
			refresh_len_out <= run_reg;
			refresh_cnt_out <= refresh_cnt_out + 8'h01;
			run_reg         <= 8'h00;
		end
	end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the chip-select, refresh and bus output block
`timescale 1ns/1ns
module testbench;
	import csr_pkg::*;
	logic        clk_in, rst_in, reg_wr_in, reg_rd_in, cyc_start_in, cyc_mem_in, cyc_read_in;
	logic        cyc_lower_in, cyc_upper_in, cyc_end_in, cyc_busy_out, hold_req_in, hold_want;
	logic        strap_addr_en_in, float_mode_in, hold_ack_out, ad_addr_drive_out;
	logic        addr_split_out, mid_bus_16bit_out, first_fetch_out, read_strobe_n_out;
	logic        midrange_select_first_n_out, midrange_select_second_n_out;
	logic        midrange_select_third_n_out, midrange_select_fourth_n_out;
	logic        read_strobe_oe_out, dram_refresh_flag_low_n_out, dram_refresh_flag_low_oe_out;
	logic [3:0]  reg_addr_in, midrange_select_oe_out, s_mid;
	logic [15:0] reg_wdata_in, reg_rdata_out;
	logic [19:0] cyc_addr_in, fetch_addr_out;
	logic [6:0]  periph_select_n_out, s_per;
	logic [7:0]  ref_len, ref_cnt;
	logic        s_rd, s_w16, s_split;
	int          fails, n_checks;

	csr_bus_outputs DUT (.*, .bus_clk_out());
	csr_ext_bus_model u_ext (
		.clk_in, .rst_in, .hold_want_in(hold_want), .hold_ack_in(hold_ack_out),
		.refresh_n_in(dram_refresh_flag_low_n_out), .refresh_oe_in(dram_refresh_flag_low_oe_out),
		.hold_req_out(hold_req_in), .refresh_len_out(ref_len), .refresh_cnt_out(ref_cnt)
	);

	task automatic final_report();
		$display("Checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tend(input string t);
		$display("Test %s done", t);
	endtask
	task automatic do_reset(input logic s);
		strap_addr_en_in <= s;
		rst_in           <= 1'b1;
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		{reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		{reg_addr_in, reg_rd_in} <= {a, 1'b1};
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_in);
		chk(20'(reg_rdata_out), 20'(e));
		@(posedge clk_in);
	endtask
	// One bus cycle, pins sampled in data phase
	task automatic cycle(input logic [19:0] a, input logic m, input logic r, input logic lo);
		{cyc_addr_in, cyc_mem_in, cyc_read_in, cyc_lower_in, cyc_start_in} <= {a, m, r, lo, 1'b1};
		@(posedge clk_in);
		cyc_start_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		s_mid = {midrange_select_fourth_n_out, midrange_select_third_n_out,
			midrange_select_second_n_out, midrange_select_first_n_out};
		{s_per, s_rd, s_w16, s_split} = {periph_select_n_out, read_strobe_n_out,
			mid_bus_16bit_out, addr_split_out};
		@(posedge clk_in);
		cyc_end_in <= 1'b1;
		@(posedge clk_in);
		cyc_end_in <= 1'b0;
		@(posedge clk_in);
		@(negedge clk_in);
		chk(20'(cyc_busy_out), 20'h0);
		@(posedge clk_in);
	endtask
	task automatic wait_ack(input logic v);
		for (int k = 0; k < 30; k++) begin
			@(negedge clk_in);
			if (hold_ack_out === v) break;
		end
		chk(20'(hold_ack_out), 20'(v));
		if (hold_ack_out !== v) begin
			final_report();
		end
	endtask

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	initial begin
		logic [15:0] rst_tab [7];
		rst_tab = '{MID_BASE_RST, PERIPH_BASE_RST, MID_PERIPH_RST, BUS_WIDTH_RST,
			REFRESH_RST, REGION_CTRL_RST, REGION_CTRL_RST};
		fails = 0;
		n_checks = 0;
		{reg_wr_in, reg_rd_in, cyc_start_in, cyc_end_in, cyc_upper_in, float_mode_in} <= '0;
		{reg_addr_in, reg_wdata_in, cyc_addr_in, hold_want} <= '0;
		{cyc_mem_in, cyc_read_in, cyc_lower_in} <= '0;
		do_reset(1'b0);
		for (int i = 0; i < 7; i++) begin
			rd(4'(i), rst_tab[i]);
		end
		wr(OFS_STATUS, 16'hFFFF);
		wr(4'h8, 16'hFFFF);
		rd(OFS_STATUS, 16'h0000);
		rd(4'h8, 16'h0000);
		tend("registers");
		for (int i = 0; i < 4; i++) begin
			wr(OFS_BUS_WIDTH, {14'h0, i[0], 1'b0});
			cycle(20'(i) << 11, 1'b1, 1'b1, 1'b0);
			chk(20'(s_mid), 20'(4'(~(4'h1 << i))));
			chk(20'(s_w16), 20'(i[0]));
			chk(20'(s_rd), 20'h0);
		end
		wr(OFS_MID_PERIPH, 16'h00C0);
		@(negedge clk_in);
		chk(20'(midrange_select_oe_out[3:1]), 20'h0);
		@(posedge clk_in);
		cycle(20'h01800, 1'b1, 1'b1, 1'b0);
		chk(20'(s_mid[0]), 20'h0);
		tend("midrange");
		wr(OFS_MID_PERIPH, MID_PERIPH_RST);
		wr(OFS_PERIPH_BASE, 16'h0010);
		for (int i = 0; i < 7; i++) begin
			cycle(20'h08000 | (20'(i) << 8), 1'b0, 1'b0, 1'b0);
			chk(20'(s_per), (i == 4) ? 20'h7F : 20'(7'(~(7'h01 << i))));
			chk(20'({s_rd, s_mid}), 20'h1F);
		end
		tend("peripheral");
		wr(OFS_MID_PERIPH, 16'h0000);
		cycle(20'h00002, 1'b0, 1'b0, 1'b0);
		chk(20'(s_per), 20'h3F);
		cycle(20'h00004, 1'b0, 1'b0, 1'b0);
		chk(20'(s_per), 20'h5F);
		hold_want <= 1'b1;
		wait_ack(1'b1);
		repeat (3) @(negedge clk_in);
		chk({13'h0, read_strobe_oe_out, periph_select_n_out[6:5], midrange_select_first_n_out,
			midrange_select_second_n_out, midrange_select_third_n_out}, 20'h17);
		@(posedge clk_in);
		hold_want <= 1'b0;
		wait_ack(1'b0);
		@(posedge clk_in);
		tend("hold");
		wr(OFS_REFRESH, 16'h8014);
		for (int k = 0; k < 400 && ref_cnt < 8'h02; k++) begin
			@(negedge clk_in);
		end
		chk(20'(ref_len), 20'(REFRESH_TOTAL_CYC));
		chk(20'(ref_cnt), 20'h2);
		if (ref_cnt < 8'h02) begin
			final_report();
		end
		@(posedge clk_in);
		wr(OFS_REFRESH, 16'h0000);
		repeat (20) @(posedge clk_in);
		tend("refresh");
		wr(OFS_LOWER_CTRL, 16'h0080);
		cycle(20'h40000, 1'b1, 1'b1, 1'b1);
		chk(20'(s_split), 20'h0);
		do_reset(1'b1);
		rd(OFS_STATUS, 16'h0001);
		wr(OFS_LOWER_CTRL, 16'h0080);
		cycle(20'h40000, 1'b1, 1'b1, 1'b1);
		chk(20'(s_split), 20'h1);
		tend("strap");
		final_report();
	end
endmodule
